// [cc_pkg.sv]
// Package: constants for the counter array capture/compare module
// Notes on behaviour
// - Selected pin edge copies counter into capture register
// - Rise/fall enables choose rising, falling or both
// - Every capture sets the module event flag
// - Flag set raises interrupt when module enabled
// - Flag stays set until software clears it
// - Live pin level readable to identify edge
// - Comparator off: no toggle, PWM output low
// - Overflow interrupt on selected counter bit overflow
// - Auto-reload select steers compare byte accesses
// - PWM match sets flag only if enabled
// - All 8..11-bit PWM modules share cycle length
// - 8-bit PWM encoding with cycle select 00
// - 9/10/11-bit PWM use cycle select 01/10/11
// - 16-bit PWM by wide select plus PWM bit
// - Timer, high-speed, frequency output mode encodings
package cc_pkg;
  // Mode register bit positions
  localparam int MODE_PWM16_BIT = 7;
  localparam int MODE_CMP_EN_BIT = 6;
  localparam int MODE_RISE_BIT = 5;
  localparam int MODE_FALL_BIT = 4;
  localparam int MODE_MATCH_BIT = 3;
  localparam int MODE_TOGGLE_BIT = 2;
  localparam int MODE_PWM_BIT = 1;
  localparam int MODE_IRQ_EN_BIT = 0;
  // Config register bit positions
  localparam int CFG_ARSEL_BIT = 7;
  localparam int CFG_OVF_IE_BIT = 5;
  localparam int CFG_CYCLE_LENGTH_SELECT_LSB = 0;
  // Reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // Cycle-length select codes
  localparam logic [1:0] CYCLE_LENGTH_SELECT_8 = 2'h0;
  localparam logic [1:0] CYCLE_LENGTH_SELECT_9 = 2'h1;
  localparam logic [1:0] CYCLE_LENGTH_SELECT_10 = 2'h2;
  localparam logic [1:0] CYCLE_LENGTH_SELECT_11 = 2'h3;

  typedef enum logic [2:0] {
    MODE_IDLE, MODE_CAPTURE, MODE_SW_TIMER, MODE_HS_OUT,
    MODE_FREQ_OUT, MODE_PWM_N, MODE_PWM16
  } op_mode_t;
endpackage

// [cc_mode_decode.sv]
// Decoder from mode register bits to an operating mode
`timescale 1ns/1ps
`default_nettype none
module cc_mode_decode
(
  // Configuration
  input  wire logic [7:0]       mode_i,
  // Decoded mode
  output var  cc_pkg::op_mode_t op_o
);
  logic pwm16;
  logic rise;
  logic fall;
  logic match;
  logic tog;
  logic pwm;

  // Field extraction
  assign pwm16 = mode_i[cc_pkg::MODE_PWM16_BIT];
  assign rise  = mode_i[cc_pkg::MODE_RISE_BIT];
  assign fall  = mode_i[cc_pkg::MODE_FALL_BIT];
  assign match = mode_i[cc_pkg::MODE_MATCH_BIT];
  assign tog   = mode_i[cc_pkg::MODE_TOGGLE_BIT];
  assign pwm   = mode_i[cc_pkg::MODE_PWM_BIT];

  // Mode table
  always_comb
  begin
    op_o = cc_pkg::MODE_IDLE;
    if ((rise || fall) && !match && !tog && !pwm)
      op_o = cc_pkg::MODE_CAPTURE;
    else if (!rise && !fall)
    begin
      if (pwm && !tog && pwm16)
        op_o = cc_pkg::MODE_PWM16;
      else if (pwm && !tog)
        op_o = cc_pkg::MODE_PWM_N;
      else if (match && !tog && !pwm)
        op_o = cc_pkg::MODE_SW_TIMER;
      else if (match && tog && !pwm)
        op_o = cc_pkg::MODE_HS_OUT;
      else if (!match && tog && pwm)
        op_o = cc_pkg::MODE_FREQ_OUT;
    end
  end
endmodule
`default_nettype wire

// [cc_module.sv]
// Capture/compare module of the counter array
`timescale 1ns/1ps
`default_nettype none
module cc_module
(
  // Clock and control
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        clk_en_i,
  // Configuration
  input  wire logic [7:0]  module_mode_reg_i,
  input  wire logic [7:0]  pwm_config_reg_i,
  // Shared counter
  input  wire logic [15:0] counter_i,
  // Software compare byte access
  input  wire logic        low_wr_i,
  input  wire logic        high_wr_i,
  input  wire logic [7:0]  wr_data_i,
  input  wire logic        flag_clear_i,
  // Pin
  input  wire logic        module_pin_i,
  // Status
  output var  logic [7:0]  compare_low_byte_o,
  output var  logic [7:0]  compare_high_byte_o,
  output var  logic [15:0] capture_value_o,
  output var  logic [15:0] reload_value_o,
  output var  logic        module_event_flag_o,
  output var  logic        irq_o,
  output var  logic        overflow_irq_o,
  output var  logic        pin_level_o,
  output var  logic        module_pin_o
);
  cc_pkg::op_mode_t op;
  logic [15:0] cap_reg, cap_next;
  logic [15:0] arl_reg, arl_next;
  logic        flag_reg, flag_next;
  logic        pin_reg, pin_next;
  logic        out_reg, out_next;
  logic        irq_reg, irq_next;
  logic        ovf_reg, ovf_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [7:0]  lo_reg, lo_next;
  logic [7:0]  hi_reg, hi_next;
  logic        rise_ev;
  logic        fall_ev;
  logic        capture;
  logic        match;
  logic        ovf_ev;
  logic        arsel;
  logic        cmp_en;
  logic [1:0]  cycle_length_select;
  logic [15:0] mask;

  cc_mode_decode u_dec
  (
    .mode_i (module_mode_reg_i),
    .op_o   (op)
  );

  // Shared config fields, plus the comparator enable from the module mode register
  assign arsel  = pwm_config_reg_i[cc_pkg::CFG_ARSEL_BIT];
  assign cmp_en = module_mode_reg_i[cc_pkg::MODE_CMP_EN_BIT];
  assign cycle_length_select  = pwm_config_reg_i[cc_pkg::CFG_CYCLE_LENGTH_SELECT_LSB +: 2];

  // Cycle mask for the shared n-bit PWM length
  always_comb
  begin
    case (cycle_length_select)
      cc_pkg::CYCLE_LENGTH_SELECT_8:  mask = 16'h00ff;
      cc_pkg::CYCLE_LENGTH_SELECT_9:  mask = 16'h01ff;
      cc_pkg::CYCLE_LENGTH_SELECT_10: mask = 16'h03ff;
      cc_pkg::CYCLE_LENGTH_SELECT_11: mask = 16'h07ff;
      default:          mask = 16'h00ff;
    endcase
  end

  // Edge, match and overflow events
  assign rise_ev = module_pin_i && !pin_reg;
  assign fall_ev = !module_pin_i && pin_reg;
  assign capture = (op == cc_pkg::MODE_CAPTURE) &&
                   ((rise_ev && module_mode_reg_i[cc_pkg::MODE_RISE_BIT]) ||
                    (fall_ev && module_mode_reg_i[cc_pkg::MODE_FALL_BIT]));
  assign match = cmp_en && (op != cc_pkg::MODE_CAPTURE) &&
                 (op != cc_pkg::MODE_IDLE) &&
                 (((op == cc_pkg::MODE_PWM_N) &&
                   ((counter_i & mask) == (cap_reg & mask))) ||
                  ((op != cc_pkg::MODE_PWM_N) && (counter_i == cap_reg)));
  assign ovf_ev = ((cnt_reg & mask) == mask) &&
                  ((counter_i & mask) == 16'h0000) &&
                  (counter_i != cnt_reg);

  // Next-state logic
  always_comb
  begin
    cap_next  = cap_reg;
    arl_next  = arl_reg;
    flag_next = flag_reg;
    pin_next  = module_pin_i;
    cnt_next  = counter_i;
    out_next  = out_reg;
    // Software clear first, so a same-cycle event wins
    if (flag_clear_i)
      flag_next = 1'b0;
    // Register steering by auto-reload select
    if (low_wr_i)
    begin
      if (arsel)
        arl_next[7:0] = wr_data_i;
      else
        cap_next[7:0] = wr_data_i;
    end
    if (high_wr_i)
    begin
      if (arsel)
        arl_next[15:8] = wr_data_i;
      else
        cap_next[15:8] = wr_data_i;
    end
    if (capture)
    begin
      cap_next  = counter_i;
      flag_next = 1'b1;
    end
    // Compare-driven output and flag
    case (op)
      cc_pkg::MODE_SW_TIMER:
        if (match)
          flag_next = 1'b1;
      cc_pkg::MODE_HS_OUT:
        if (match)
        begin
          flag_next = 1'b1;
          out_next  = !out_reg;
        end
      cc_pkg::MODE_FREQ_OUT:
        if (match)
          out_next = !out_reg;
      cc_pkg::MODE_PWM_N, cc_pkg::MODE_PWM16:
      begin
        if (!cmp_en)
          out_next = 1'b0;
        else if (match)
          out_next = 1'b1;
        else if ((counter_i & mask) == 16'h0000 ||
                 (op == cc_pkg::MODE_PWM16 && counter_i == 16'h0000))
          out_next = 1'b0;
        if (match && module_mode_reg_i[cc_pkg::MODE_MATCH_BIT])
          flag_next = 1'b1;
        // Reload compare at cycle wrap in n-bit mode
        if (op == cc_pkg::MODE_PWM_N && ovf_ev)
          cap_next = arl_reg;
      end
      default:
        out_next = out_reg;
    endcase
    irq_next = flag_next &&
               module_mode_reg_i[cc_pkg::MODE_IRQ_EN_BIT];
    ovf_next = ovf_ev &&
               pwm_config_reg_i[cc_pkg::CFG_OVF_IE_BIT];
    lo_next  = arsel ? arl_next[7:0] : cap_next[7:0];
    hi_next  = arsel ? arl_next[15:8] : cap_next[15:8];
  end

  // State registers
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      cap_reg  <= cc_pkg::WORD_RESET;
      arl_reg  <= cc_pkg::WORD_RESET;
      flag_reg <= 1'b0;
      pin_reg  <= 1'b0;
      out_reg  <= 1'b0;
      irq_reg  <= 1'b0;
      ovf_reg  <= 1'b0;
      cnt_reg  <= cc_pkg::WORD_RESET;
      lo_reg   <= 8'h00;
      hi_reg   <= 8'h00;
    end
    else if (clk_en_i)
    begin
      cap_reg  <= cap_next;
      arl_reg  <= arl_next;
      flag_reg <= flag_next;
      pin_reg  <= pin_next;
      out_reg  <= out_next;
      irq_reg  <= irq_next;
      ovf_reg  <= ovf_next;
      cnt_reg  <= cnt_next;
      lo_reg   <= lo_next;
      hi_reg   <= hi_next;
    end
  end

  // Outputs straight from flops
  assign compare_low_byte_o  = lo_reg;
  assign compare_high_byte_o = hi_reg;
  assign capture_value_o     = cap_reg;
  assign reload_value_o      = arl_reg;
  assign module_event_flag_o = flag_reg;
  assign irq_o               = irq_reg;
  assign overflow_irq_o      = ovf_reg;
  assign pin_level_o         = pin_reg;
  assign module_pin_o        = out_reg;

  // Capture loads the counter value
  property p_capture_load;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (capture && clk_en_i) |=> (cap_reg == $past(counter_i));
  endproperty
  a_capture_load: assert property (p_capture_load)
    else $error("capture did not load counter");

  // Capture sets the flag
  property p_capture_flag;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (capture && clk_en_i) |=> flag_reg;
  endproperty
  a_capture_flag: assert property (p_capture_flag)
    else $error("capture did not set flag");

  // Rising-only mode ignores falling edges
  property p_edge_select;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (op == cc_pkg::MODE_CAPTURE && fall_ev &&
       !module_mode_reg_i[cc_pkg::MODE_FALL_BIT]) |-> !capture;
  endproperty
  a_edge_select: assert property (p_edge_select)
    else $error("unselected edge captured");

  // Interrupt follows enabled flag
  property p_irq;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (clk_en_i && flag_next &&
       module_mode_reg_i[cc_pkg::MODE_IRQ_EN_BIT]) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not raised");

  // Flag holds without software clear
  property p_flag_hold;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (flag_reg && !flag_clear_i) |=> flag_reg;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag dropped without clear");

  // Pin level mirrors pin one cycle later
  property p_pin_level;
    @(posedge mclk_i) disable iff (sys_rst_i)
      clk_en_i |=> (pin_level_o == $past(module_pin_i));
  endproperty
  a_pin_level: assert property (p_pin_level)
    else $error("pin level not mirrored");

  // PWM output low with comparator off
  property p_pwm_off;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (clk_en_i && !cmp_en && (op == cc_pkg::MODE_PWM_N ||
       op == cc_pkg::MODE_PWM16)) |=> !module_pin_o;
  endproperty
  a_pwm_off: assert property (p_pwm_off)
    else $error("PWM output high with comparator off");

  // Low byte write steered by auto-reload select
  property p_steer;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (clk_en_i && low_wr_i && arsel && !capture && !ovf_ev) |=>
        (reload_value_o[7:0] == $past(wr_data_i));
  endproperty
  a_steer: assert property (p_steer)
    else $error("auto-reload write not steered");

  // Overflow interrupt when enabled
  property p_ovf;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (clk_en_i && ovf_ev && pwm_config_reg_i[cc_pkg::CFG_OVF_IE_BIT])
        |=> overflow_irq_o;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow interrupt missing");
endmodule
`default_nettype wire

// [pin_model.sv]
// External signal source on the module pin
`timescale 1ns/1ps
`default_nettype none
module pin_model
(
  // Clock
  input  wire logic mclk_i,
  // Pin
  output var  logic pin_o
);
  // Pin moves only just after a clock edge
  task automatic drive(input logic lvl);
    @(posedge mclk_i);
    #1 pin_o = lvl;
  endtask
  initial pin_o = 1'b0;
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the capture/compare module
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        mclk_i = 1'b0;
  logic        rst    = 1'b1;
  logic        clk_en = 1'b1;
  logic [7:0]  mode   = 8'h00;
  logic [7:0]  cfg    = 8'h00;
  logic [15:0] cnt    = 16'h0000;
  logic        lo_wr  = 1'b0;
  logic        hi_wr  = 1'b0;
  logic [7:0]  wdata  = 8'h00;
  logic        fclr   = 1'b0;
  logic        pin;
  logic [7:0]  lo_b, hi_b;
  logic [15:0] cap, rld;
  logic        flag, irq, ovf, plev, pout, seen;
  int          err_count = 0;
  int          compares  = 0;

  // Clock generation
  always #2.5 mclk_i = ~mclk_i;

  pin_model pin_u (.mclk_i(mclk_i), .pin_o(pin));

  cc_module dut_u (
    .mclk_i(mclk_i), .sys_rst_i(rst), .clk_en_i(clk_en),
    .module_mode_reg_i(mode), .pwm_config_reg_i(cfg),
    .counter_i(cnt), .low_wr_i(lo_wr), .high_wr_i(hi_wr),
    .wr_data_i(wdata), .flag_clear_i(fclr), .module_pin_i(pin),
    .compare_low_byte_o(lo_b), .compare_high_byte_o(hi_b),
    .capture_value_o(cap), .reload_value_o(rld),
    .module_event_flag_o(flag), .irq_o(irq), .overflow_irq_o(ovf),
    .pin_level_o(plev), .module_pin_o(pout));

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Compare one value
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Advance n cycles, landing just after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  // Pin transition, then let the result settle
  task automatic edge_to(input logic lvl);
    pin_u.drive(lvl);
    tick(3);
  endtask

  // Software clears the event flag
  task automatic clr();
    fclr = 1'b1;
    tick(1);
    fclr = 1'b0;
    tick(2);
    chk("flag_clr", 16'h0, {15'h0, flag});
  endtask

  // Byte writes at the compare addresses
  task automatic wr(input logic [7:0] lo, input logic [7:0] hi);
    wdata = lo;
    lo_wr = 1'b1;
    tick(1);
    lo_wr = 1'b0;
    wdata = hi;
    hi_wr = 1'b1;
    tick(1);
    hi_wr = 1'b0;
    tick(2);
  endtask

  // Sweep the counter over one 8-bit cycle
  task automatic sweep(input logic chk_out);
    for (int i = 0; i < 256; i++)
    begin
      cnt = 16'(i);
      tick(1);
      if (chk_out)
        chk("pin_out", 16'h0, {15'h0, pout});
    end
  endtask

  // Capture on each edge selection
  task automatic t_capture();
    mode = 8'h21;
    cnt  = 16'h1234;
    edge_to(1'b1);
    chk("cap_rise", 16'h1234, cap);
    chk("flag", 16'h1, {15'h0, flag});
    chk("irq", 16'h1, {15'h0, irq});
    tick(6);
    chk("flag_hold", 16'h1, {15'h0, flag});
    clr();
    chk("irq_clr", 16'h0, {15'h0, irq});
    mode = 8'h10;
    cnt  = 16'ha5c3;
    edge_to(1'b0);
    chk("cap_fall", 16'ha5c3, cap);
    clr();
    cnt = 16'h0f0f;
    edge_to(1'b1);
    chk("cap_nofall", 16'ha5c3, cap);
    chk("flag_none", 16'h0, {15'h0, flag});
    mode = 8'h31;
    cnt  = 16'h7e81;
    edge_to(1'b0);
    chk("cap_both_f", 16'h7e81, cap);
    chk("lvl_f", 16'h0, {15'h0, plev});
    clr();
    cnt = 16'h8001;
    edge_to(1'b1);
    chk("cap_both_r", 16'h8001, cap);
    chk("lvl_r", 16'h1, {15'h0, plev});
    clr();
    mode = 8'h20;
    edge_to(1'b0);
    cnt = 16'h4242;
    edge_to(1'b1);
    chk("flag_noie", 16'h1, {15'h0, flag});
    chk("irq_noie", 16'h0, {15'h0, irq});
    clr();
    $display("test capture done");
  endtask

  // Auto-reload select steers byte writes
  task automatic t_arsel();
    mode = 8'h00;
    cfg  = 8'h80;
    wr(8'h3c, 8'hc3);
    chk("reload", 16'hc33c, rld);
    chk("bytes_r", 16'hc33c, {hi_b, lo_b});
    cfg = 8'h00;
    wr(8'h96, 8'h69);
    chk("capreg", 16'h6996, cap);
    chk("bytes_c", 16'h6996, {hi_b, lo_b});
    chk("reload_kept", 16'hc33c, rld);
    $display("test arsel done");
  endtask

  // PWM output and match flag
  task automatic t_pwm();
    mode = 8'h0a;
    sweep(1'b1);
    mode = 8'h42;
    sweep(1'b0);
    chk("flag_nomatch", 16'h0, {15'h0, flag});
    mode = 8'h4a;
    sweep(1'b0);
    chk("flag_match", 16'h1, {15'h0, flag});
    clr();
    $display("test pwm done");
  endtask

  // Overflow interrupt at each cycle length
  task automatic t_ovf();
    mode = 8'h42;
    for (int n = 0; n < 4; n++)
    for (int en = 0; en < 2; en++)
    begin
      cfg  = en ? 8'(8'h20 | n) : 8'(n);
      cnt  = 16'((1 << (8 + n)) - 1);
      tick(2);
      cnt  = 16'(1 << (8 + n));
      seen = 1'b0;
      repeat (4)
      begin
        tick(1);
        if (ovf === 1'b1)
          seen = 1'b1;
      end
      chk("ovf", 16'(en), {15'h0, seen});
    end
    cfg = 8'h00;
    $display("test overflow done");
  endtask

  // Timer, high-speed and frequency output modes
  task automatic t_modes();
    cfg  = 8'h00;
    mode = 8'h00;
    wr(8'h10, 8'h00);
    mode = 8'h4c;
    cnt  = 16'h0010;
    tick(1);
    cnt  = 16'h0011;
    tick(1);
    chk("hs_out", 16'h1, {15'h0, pout});
    chk("hs_flag", 16'h1, {15'h0, flag});
    clr();
    mode = 8'h0c;
    cnt  = 16'h0010;
    tick(1);
    cnt  = 16'h0011;
    tick(1);
    chk("hs_off", 16'h1, {15'h0, pout});
    mode = 8'h46;
    cnt  = 16'h0010;
    tick(1);
    cnt  = 16'h0011;
    tick(1);
    chk("freq_out", 16'h0, {15'h0, pout});
    chk("freq_flag", 16'h0, {15'h0, flag});
    mode = 8'h48;
    cnt  = 16'h0010;
    tick(1);
    cnt  = 16'h0011;
    tick(1);
    chk("tmr_out", 16'h0, {15'h0, pout});
    chk("tmr_flag", 16'h1, {15'h0, flag});
    clr();
    $display("test modes done");
  endtask

  // Main sequence
  initial
  begin
    tick(8);
    rst = 1'b0;
    tick(1);
    t_capture();
    t_arsel();
    t_pwm();
    t_ovf();
    t_modes();
    end_sim();
  end
endmodule
`default_nettype wire
